/* File: bench/pmc_cmd_bank_tb.sv */
// self-checking bench for the power-converter command bank
`timescale 1ns/1ps
module pmc_cmd_bank_tb
   import pmc_pkg::*;
;
   localparam logic [7:0] CODES [14] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A,
                                         8'h32, 8'h33, 8'h35, 8'h36, 8'h37, 8'h39, 8'h40};
   logic        clk_sys_i = 1'b0;
   logic        rstn_i;
   pmc_req_t    req;
   pmc_rsp_t    rsp;
   logic [7:0]  vmode, dreq, duty;
   logic [15:0] strap, vcmd, vin, iraw, vsense, vref, gain, scale, iout;
   logic [1:0]  msel;
   logic [10:0] fsw;
   logic [3:0]  gid, rcnt, rpos;
   logic        conv, ovf;
   int          err_total = 0;
   int          check_count = 0;

   always #4 clk_sys_i = ~clk_sys_i;

   pmc_cmd_bank uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req), .vout_mode_i(vmode),
      .strap_vout_i(strap), .vout_cmd_i(vcmd), .margin_sel_i(msel), .vin_i(vin),
      .iout_raw_i(iraw), .vout_sense_i(vsense), .duty_req_i(dreq), .rsp_o(rsp),
      .vref_o(vref), .conv_en_o(conv), .duty_o(duty), .fsw_khz_o(fsw), .loop_gain_o(gain),
      .monitor_scale_o(scale), .group_id_o(gid), .rail_count_o(rcnt), .rail_pos_o(rpos),
      .iout_o(iout), .ov_fault_o(ovf));
   pmc_host_model host (.clk_sys_i(clk_sys_i), .rsp_i(rsp), .req_o(req));

   task automatic test_done;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done

   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk_w

   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : wt

   task automatic xf(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                     input logic eack, output logic [15:0] rd);
      logic ok, ack;
      host.xfer(wr, code, wd, ok, ack, rd);
      if (!ok) begin
         chk_w(16'hDEAD, 16'h0000);
         test_done();
      end
      chk_w({15'h0000, ack}, {15'h0000, eack});
   endtask : xf

   task automatic t_reset;
      logic [15:0] d;
      chk_w(vref, 16'h0000);
      for (int i = 0; i < 14; i++) begin
         xf(1'b0, CODES[i], 16'h0000, 1'b1, d);
         chk_w(d, (i == 0) ? 16'h006E : (i == 13) ? 16'hFFFF : 16'h0000);
      end
   endtask : t_reset

   task automatic t_rw;
      logic [15:0] d;
      for (int i = 1; i < 14; i++) begin
         if (i == 11 || i == 12) continue;
         xf(1'b1, CODES[i], {8'hA5, CODES[i]}, 1'b1, d);
         xf(1'b0, CODES[i], 16'h0000, 1'b1, d);
         chk_w(d, {8'hA5, CODES[i]});
      end
      wt(3);
      chk_w(gain, 16'hA529);
      chk_w(scale, 16'hA52A);
      xf(1'b1, 8'h37, 16'hFFFF, 1'b1, d);
      xf(1'b0, 8'h37, 16'h0000, 1'b1, d);
      chk_w(d, 16'h0FFF);
      xf(1'b1, 8'h37, 16'h0B30, 1'b1, d);
      wt(3);
      chk_w({4'h0, gid, rcnt, rpos}, 16'h0B30);
      xf(1'b1, 8'h39, 16'h1234, 1'b0, d);
      xf(1'b0, 8'h39, 16'h0000, 1'b1, d);
      chk_w(d, 16'h0000);
      xf(1'b0, 8'h30, 16'h0000, 1'b0, d);
      chk_w(d, 16'h0000);
   endtask : t_rw

   task automatic t_volt;
      logic [15:0] d;
      xf(1'b1, 8'h27, 16'h0000, 1'b1, d);
      xf(1'b1, 8'h28, 16'h0000, 1'b1, d);
      xf(1'b1, 8'h24, 16'h0100, 1'b1, d);
      xf(1'b0, 8'h24, 16'h0000, 1'b1, d);
      chk_w(d, 16'h006E);
      vcmd = 16'h0200;
      wt(5);
      chk_w(vref, 16'h006E);
      xf(1'b1, 8'h25, 16'h0050, 1'b1, d);
      xf(1'b1, 8'h26, 16'h0030, 1'b1, d);
      msel = 2'b01;
      wt(5);
      chk_w(vref, 16'h0050);
      msel = 2'b10;
      wt(5);
      chk_w(vref, 16'h0030);
      // 0x20 rise at 2 per 125-cycle tick needs 2000 cycles
      xf(1'b1, 8'h27, 16'h0002, 1'b1, d);
      msel = 2'b01;
      wt(300);
      chk_w({15'h0000, vref > 16'h0030 && vref < 16'h0040}, 16'h0001);
      for (int i = 0; i < 2500 && vref !== 16'h0050; i++) wt(1);
      chk_w(vref, 16'h0050);
      xf(1'b1, 8'h27, 16'h0000, 1'b1, d);
      xf(1'b1, 8'h28, 16'h0400, 1'b1, d);
      iraw = 16'h0010;
      wt(5);
      chk_w(vref, 16'h0040);
      chk_w(iout, 16'h0010);
   endtask : t_volt

   task automatic t_misc;
      logic [15:0] d;
      logic [15:0] vins [5] = '{16'h0010, 16'h0030, 16'h0025, 16'h0020, 16'h0025};
      logic        cexp [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      xf(1'b1, 8'h32, 16'h0040, 1'b1, d);
      xf(1'b1, 8'h33, 16'h0190, 1'b1, d);
      dreq = 8'h80;
      wt(4);
      chk_w({8'h00, duty}, 16'h0040);
      chk_w({5'h00, fsw}, 16'h0190);
      dreq = 8'h20;
      wt(4);
      chk_w({8'h00, duty}, 16'h0020);
      xf(1'b1, 8'h35, 16'h0030, 1'b1, d);
      xf(1'b1, 8'h36, 16'h0020, 1'b1, d);
      for (int i = 0; i < 5; i++) begin
         vin = vins[i];
         wt(4);
         chk_w({15'h0000, conv}, {15'h0000, cexp[i]});
      end
      xf(1'b1, 8'h40, 16'h0080, 1'b1, d);
      vsense = 16'h0081;
      wt(4);
      chk_w({15'h0000, ovf}, 16'h0001);
      vsense = 16'h0080;
      wt(4);
      chk_w({15'h0000, ovf}, 16'h0000);
      // only 000, 001 and 010 are mode codes the bank accepts
      for (int m = 0; m < 8; m++) begin
         vmode = {m[2:0], 5'h00};
         xf(1'b1, 8'h26, 16'h0030, m < 3, d);
      end
      vmode = 8'h00;
   endtask : t_misc

   initial begin
      rstn_i = 1'b0;
      vmode = 8'h00;
      strap = 16'h0064;
      {vcmd, vin, iraw, vsense} = '0;
      msel = 2'b00;
      dreq = 8'h00;
      wt(20);
      rstn_i = 1'b1;
      wt(2);
      t_reset();
      t_rw();
      t_volt();
      t_misc();
      test_done();
   end
endmodule : pmc_cmd_bank_tb

/* File: bench/pmc_host_model.sv */
// host-side model issuing word transfers on the command port
`timescale 1ns/1ps
module pmc_host_model
   import pmc_pkg::*;
(
   input  wire logic     clk_sys_i,
   input  wire pmc_rsp_t rsp_i,
   output pmc_req_t      req_o
);
   initial req_o = '0;
   // one request cycle; answer taken the cycle valid is seen, at most 4 cycles
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
                       output logic ok, output logic ack, output logic [15:0] rdata);
      ok = 1'b0;
      ack = 1'b0;
      rdata = 16'h0000;
      @(negedge clk_sys_i);
      req_o = {wr, ~wr, code, wdata};
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge clk_sys_i);
         // idle lines scrambled so stale code or data never looks valid
         if (i == 0) req_o = {2'b00, ~code, ~wdata};
         if (rsp_i.valid === 1'b1) begin
            ok = 1'b1;
            ack = rsp_i.ack;
            rdata = rsp_i.data;
         end
      end
   endtask : xfer
endmodule : pmc_host_model

/* File: hdl/pmc_cmd_bank.sv */
// output configuration command bank with setpoint ramp and limits
`timescale 1ns/1ps
`include "pmc_params.svh"

// Operation
// - ceiling writes and targets never exceed 110 percent of strap voltage
// - margin-high target at 0x25, 16-bit, used while margin-high selected
// - margin-low target at 0x26, 16-bit, used while margin-low selected
// - setpoint ramps toward target at the programmed rate
// - droop slope at 0x28 lowers the reference with load current
// - sense loop gain word kept at 0x29
// - sense divider scale word kept at 0x2A
// - duty cycle capped by maximum at 0x32
// - switching frequency in kHz from word at 0x33
// - conversion starts once input reaches turn-on threshold
// - running conversion stops when input falls to turn-off threshold
// - interleave group id in bits 11:8 of 0x37
// - interleave unit count in bits 7:4
// - rail position in bits 3:0, driven out on rail_pos_o
// - read-only current offset at 0x39 added to current readings
// - over-voltage fault threshold word at 0x40
// - mode field 000 linear, 001 VID, 010 direct; others refuse words 0x24, 0x25, 0x26 and 0x40
module pmc_cmd_bank
   import pmc_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   input  wire pmc_req_t    req_i,
   input  wire logic [7:0]  vout_mode_i,
   input  wire logic [15:0] strap_vout_i,
   input  wire logic [15:0] vout_cmd_i,
   input  wire logic [1:0]  margin_sel_i,
   input  wire logic [15:0] vin_i,
   input  wire logic [15:0] iout_raw_i,
   input  wire logic [15:0] vout_sense_i,
   input  wire logic [7:0]  duty_req_i,
   output pmc_rsp_t         rsp_o,
   output logic [15:0]      vref_o,
   output logic             conv_en_o,
   output logic [7:0]       duty_o,
   output logic [10:0]      fsw_khz_o,
   output logic [15:0]      loop_gain_o,
   output logic [15:0]      monitor_scale_o,
   output logic [3:0]       group_id_o,
   output logic [3:0]       rail_count_o,
   output logic [3:0]       rail_pos_o,
   output logic [15:0]      iout_o,
   output logic             ov_fault_o
);

   localparam logic [7:0] CODE_TAB [`PMC_NREG] = '{
      `PMC_CODE_CEIL, `PMC_CODE_MHIGH, `PMC_CODE_MLOW, `PMC_CODE_RATE,
      `PMC_CODE_DROOP, `PMC_CODE_GAIN, `PMC_CODE_SCALE, `PMC_CODE_DUTY,
      `PMC_CODE_FSW, `PMC_CODE_VINON, `PMC_CODE_VINOFF, `PMC_CODE_ILV,
      `PMC_CODE_IOFS, `PMC_CODE_OVF};

   logic [15:0]       bank_reg [`PMC_NREG];
   logic [15:0]       bank_next [`PMC_NREG];
   logic [`PMC_NREG-1:0] hit;
   logic [15:0]       rd_val [`PMC_NREG];
   logic [15:0]       rd_data;
   logic              any_hit;
   logic              vfmt_hit;
   logic              fmt_ok;
   logic              ro_hit;
   logic              wr_ok;
   logic              acc_ok;
   logic [15:0]       wr_val;
   logic [15:0]       strap_lim_reg;
   logic              strap_done_reg;
   logic [23:0]       lim_wide;
   logic [15:0]       lim_16;
   logic [15:0]       ceil_eff;
   logic [15:0]       target_raw;
   logic [15:0]       target;
   logic              sel_high;
   logic              sel_low;
   logic [15:0]       sp_reg;
   logic [15:0]       sp_next;
   pmc_ramp_t         rs_reg;
   pmc_ramp_t         rs_next;
   logic [`PMC_TICK_W-1:0] tick_cnt_reg;
   logic              tick;
   logic [10:0]       step;
   logic [15:0]       gap_up;
   logic [15:0]       gap_dn;
   logic [21:0]       droop_prod;
   logic [15:0]       droop;
   logic [15:0]       vref_next;
   logic [10:0]       duty_max;
   logic              conv_next;
   logic [15:0]       iofs_ext;
   pmc_rsp_t          rsp_next;

   // command decode, one comparator per entry
   genvar g;
   generate
      for (g = 0; g < `PMC_NREG; g++) begin : g_entry
         assign hit[g]       = (req_i.code == CODE_TAB[g]);
         assign rd_val[g]    = hit[g] ? bank_reg[g] : 16'h0000;
         // ceiling takes the strap limit on the first edge; only a read sampled on that edge can see the 0xFFFF reset value
         assign bank_next[g] = (g == `PMC_IX_CEIL && !strap_done_reg) ? lim_16
                             : (wr_ok && hit[g]) ? wr_val : bank_reg[g];
         always_ff @(posedge clk_sys_i) begin
            if (!rstn_i) begin
               if (g == `PMC_IX_CEIL)
                  bank_reg[g] <= `PMC_RST_CEIL;
               else if (g == `PMC_IX_OVF)
                  bank_reg[g] <= `PMC_RST_OVF;
               else
                  bank_reg[g] <= `PMC_RST_OTHER;
            end else begin
               bank_reg[g] <= bank_next[g];
            end
         end
      end
   endgenerate

   // or-reduction of the one-hot read lanes
   always_comb begin
      rd_data = 16'h0000;
      for (int i = 0; i < `PMC_NREG; i++)
         rd_data = rd_data | rd_val[i];
   end

   assign any_hit  = |hit;
   assign vfmt_hit = hit[`PMC_IX_CEIL] | hit[`PMC_IX_MHIGH] | hit[`PMC_IX_MLOW]
                   | hit[`PMC_IX_OVF];
   assign fmt_ok   = (vout_mode_i[7:5] == `PMC_MODE_LINEAR)
                   | (vout_mode_i[7:5] == `PMC_MODE_VID)
                   | (vout_mode_i[7:5] == `PMC_MODE_DIRECT);
   // an unknown mode makes voltage words meaningless, so refuse them
   assign acc_ok   = any_hit && (fmt_ok || !vfmt_hit);
   assign ro_hit   = hit[`PMC_IX_IOFS];
   assign wr_ok    = req_i.wr && acc_ok && !ro_hit;

   // strap limit: 110 percent, saturated to the word
   assign lim_wide = ({8'h00, strap_vout_i} * `PMC_CEIL_PCT) / `PMC_PCT_BASE;
   assign lim_16   = (lim_wide[23:16] != 8'h00) ? 16'hFFFF : lim_wide[15:0];

   assign wr_val = hit[`PMC_IX_CEIL] ?
                      ((req_i.data > strap_lim_reg) ? strap_lim_reg : req_i.data)
                 : hit[`PMC_IX_ILV] ? (req_i.data & `PMC_ILV_MASK)
                 : req_i.data;

   // strap is sampled once, on the first cycle after reset release
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         strap_done_reg <= 1'b0;
         strap_lim_reg  <= 16'h0000;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         strap_lim_reg  <= lim_16;
      end
   end

   // target selection and ceiling clamp
   assign ceil_eff   = (bank_reg[`PMC_IX_CEIL] > strap_lim_reg) ?
                       strap_lim_reg : bank_reg[`PMC_IX_CEIL];
   assign sel_high   = (margin_sel_i == `PMC_MSEL_HIGH);
   assign sel_low    = (margin_sel_i == `PMC_MSEL_LOW);
   // codes 00 and 11 both select the nominal setpoint
   assign target_raw = sel_high ? bank_reg[`PMC_IX_MHIGH]
                     : sel_low ? bank_reg[`PMC_IX_MLOW]
                     : vout_cmd_i;
   assign target     = (target_raw > ceil_eff) ? ceil_eff : target_raw;

   // ramp: rate mantissa is setpoint steps per microsecond tick
   // free-running tick, so a ramp may wait up to one tick for its first step
   assign tick   = (tick_cnt_reg == `PMC_TICK_W'(`PMC_RAMP_TICK_CYC - 1));
   assign step   = bank_reg[`PMC_IX_RATE][`PMC_MANT_MSB:0];
   assign gap_up = target - sp_reg;
   assign gap_dn = sp_reg - target;

   always_comb begin
      rs_next = rs_reg;
      sp_next = sp_reg;
      unique case (rs_reg)
         PMC_RS_IDLE: begin
            if (target > sp_reg)
               rs_next = PMC_RS_UP;
            else if (target < sp_reg)
               rs_next = PMC_RS_DOWN;
         end
         PMC_RS_UP: begin
            // zero rate means an immediate step, no ramp
            if (target <= sp_reg)
               rs_next = PMC_RS_IDLE;
            else if (tick || step == 11'h000) begin
               if (step == 11'h000 || gap_up <= {5'h00, step})
                  sp_next = target;
               else
                  sp_next = sp_reg + {5'h00, step};
            end
         end
         PMC_RS_DOWN: begin
            if (target >= sp_reg)
               rs_next = PMC_RS_IDLE;
            else if (tick || step == 11'h000) begin
               if (step == 11'h000 || gap_dn <= {5'h00, step})
                  sp_next = target;
               else
                  sp_next = sp_reg - {5'h00, step};
            end
         end
         default: rs_next = PMC_RS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         rs_reg       <= PMC_RS_IDLE;
         sp_reg       <= 16'h0000;
         tick_cnt_reg <= '0;
      end else begin
         rs_reg       <= rs_next;
         sp_reg       <= sp_next;
         tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
      end
   end

   // load line: slope times current, scaled down, subtracted from setpoint
   assign droop_prod = bank_reg[`PMC_IX_DROOP][`PMC_MANT_MSB:0]
                     * iout_raw_i[`PMC_MANT_MSB:0];
   assign droop      = {4'h0, droop_prod[21:`PMC_DROOP_SHIFT]};
   assign vref_next  = (sp_reg > droop) ? (sp_reg - droop) : 16'h0000;

   assign duty_max  = bank_reg[`PMC_IX_DUTY][`PMC_MANT_MSB:0];
   // hysteresis: on at or above turn-on, off at or below turn-off
   // equal on and off words make the enable toggle every cycle while the input equals them
   assign conv_next = conv_en_o ?
                      (vin_i > bank_reg[`PMC_IX_VINOFF])
                    : (vin_i >= bank_reg[`PMC_IX_VINON]);
   // read-only and reset to zero, so the offset stays zero in this block
   assign iofs_ext  = {{5{bank_reg[`PMC_IX_IOFS][`PMC_MANT_MSB]}},
                       bank_reg[`PMC_IX_IOFS][`PMC_MANT_MSB:0]};

   assign rsp_next.valid = req_i.wr | req_i.rd;
   assign rsp_next.ack   = (req_i.rd && acc_ok) || wr_ok;
   assign rsp_next.data  = (req_i.rd && acc_ok) ? rd_data : 16'h0000;

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         rsp_o           <= '0;
         vref_o          <= 16'h0000;
         conv_en_o       <= 1'b0;
         duty_o          <= 8'h00;
         fsw_khz_o       <= 11'h000;
         loop_gain_o     <= 16'h0000;
         monitor_scale_o <= 16'h0000;
         group_id_o      <= 4'h0;
         rail_count_o    <= 4'h0;
         rail_pos_o      <= 4'h0;
         iout_o          <= 16'h0000;
         ov_fault_o      <= 1'b0;
      end else begin
         rsp_o           <= rsp_next;
         vref_o          <= vref_next;
         conv_en_o       <= conv_next;
         duty_o          <= ({3'h0, duty_req_i} > duty_max) ?
                            duty_max[7:0] : duty_req_i;
         fsw_khz_o       <= bank_reg[`PMC_IX_FSW][`PMC_MANT_MSB:0];
         loop_gain_o     <= bank_reg[`PMC_IX_GAIN];
         monitor_scale_o <= bank_reg[`PMC_IX_SCALE];
         group_id_o      <= bank_reg[`PMC_IX_ILV][`PMC_ILV_GID];
         rail_count_o    <= bank_reg[`PMC_IX_ILV][`PMC_ILV_CNT];
         rail_pos_o      <= bank_reg[`PMC_IX_ILV][`PMC_ILV_POS];
         iout_o          <= iout_raw_i + iofs_ext;
         ov_fault_o      <= (vout_sense_i > bank_reg[`PMC_IX_OVF]);
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   a_ceiling_capped: assert property (
      strap_done_reg |-> bank_reg[`PMC_IX_CEIL] <= strap_lim_reg)
      else $error("ceiling above strap limit");
   a_margin_high_wr: assert property (
      req_i.wr && hit[`PMC_IX_MHIGH] && fmt_ok
      |=> bank_reg[`PMC_IX_MHIGH] == $past(req_i.data) && rsp_o.ack)
      else $error("margin high write lost");
   a_margin_low_sel: assert property (
      margin_sel_i == 2'b10 && bank_reg[`PMC_IX_MLOW] <= ceil_eff
      |-> target == bank_reg[`PMC_IX_MLOW])
      else $error("margin low not targeted");
   a_ramp_step_size: assert property (
      rs_reg == PMC_RS_UP && step != 11'h000 && sp_next != sp_reg
      |-> sp_next - sp_reg <= {5'h00, step})
      else $error("ramp step too large");
   a_ro_refused: assert property (
      req_i.wr && hit[`PMC_IX_IOFS]
      |=> !rsp_o.ack && $stable(bank_reg[`PMC_IX_IOFS]))
      else $error("read-only offset written");
   a_ilv_top_zero: assert property (
      req_i.rd && hit[`PMC_IX_ILV] |=> rsp_o.data[15:12] == 4'h0)
      else $error("interleave top bits not zero");
   a_conv_start: assert property (
      !conv_en_o && vin_i >= bank_reg[`PMC_IX_VINON] |=> conv_en_o)
      else $error("conversion did not start");
   a_conv_stop: assert property (
      conv_en_o && vin_i <= bank_reg[`PMC_IX_VINOFF] |=> !conv_en_o)
      else $error("conversion did not stop");
   a_duty_capped: assert property (
      ##1 {3'h0, duty_o} <= $past(duty_max))
      else $error("duty above maximum");
   a_ov_flag: assert property (
      vout_sense_i > bank_reg[`PMC_IX_OVF] |=> ov_fault_o)
      else $error("over-voltage not flagged");
   a_bad_mode_nack: assert property (
      req_i.wr && vfmt_hit && !fmt_ok |=> rsp_o.valid && !rsp_o.ack)
      else $error("bad mode write accepted");
   a_vref_capped: assert property (
      strap_done_reg |=> vref_o <= strap_lim_reg)
      else $error("reference above strap limit");
   a_margin_high_sel: assert property (
      margin_sel_i == `PMC_MSEL_HIGH && bank_reg[`PMC_IX_MHIGH] <= ceil_eff
      |-> target == bank_reg[`PMC_IX_MHIGH])
      else $error("margin high not targeted");
   a_ramp_down_step: assert property (
      rs_reg == PMC_RS_DOWN && step != 11'h000 && sp_next != sp_reg
      |-> sp_reg - sp_next <= {5'h00, step})
      else $error("ramp down step too large");
   a_droop_lowers: assert property (
      ##1 vref_o <= $past(sp_reg))
      else $error("load line raised reference");
   a_gain_follows: assert property (
      ##1 loop_gain_o == $past(bank_reg[`PMC_IX_GAIN]))
      else $error("loop gain output stale");
   a_scale_follows: assert property (
      ##1 monitor_scale_o == $past(bank_reg[`PMC_IX_SCALE]))
      else $error("monitor scale output stale");
   a_fsw_follows: assert property (
      ##1 fsw_khz_o == $past(bank_reg[`PMC_IX_FSW][`PMC_MANT_MSB:0]))
      else $error("switching frequency output stale");
   a_ilv_fields: assert property (
      ##1 {4'h0, group_id_o, rail_count_o, rail_pos_o}
          == $past(bank_reg[`PMC_IX_ILV] & `PMC_ILV_MASK))
      else $error("interleave fields stale");
   a_ilv_top_store: assert property (
      (bank_reg[`PMC_IX_ILV] & ~`PMC_ILV_MASK) == 16'h0000)
      else $error("interleave top bits stored");
   a_iout_offset: assert property (
      ##1 iout_o == $past(iout_raw_i) + $past(iofs_ext))
      else $error("current offset not added");
   a_rsp_pulse: assert property (
      ##1 rsp_o.valid == $past(req_i.wr || req_i.rd))
      else $error("response pulse misplaced");
   a_unmapped_nack: assert property (
      (req_i.wr || req_i.rd) && !any_hit |=> !rsp_o.ack && rsp_o.data == 16'h0000)
      else $error("unmapped code answered");

   c_ceiling_clamp: cover property (
      req_i.wr && hit[`PMC_IX_CEIL] && req_i.data > strap_lim_reg);
   c_ramp_done:     cover property (rs_reg == PMC_RS_UP ##[1:300] rs_reg == PMC_RS_IDLE);
   c_conv_cycle:    cover property (conv_en_o ##[1:50] !conv_en_o);
   c_unmapped:      cover property (req_i.rd && !any_hit);
   c_margin_low:    cover property (margin_sel_i == `PMC_MSEL_LOW ##1 rs_reg == PMC_RS_DOWN);

endmodule : pmc_cmd_bank

/* File: hdl/pmc_params.svh */
// constants for the power-converter command bank
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_NREG          14
`define PMC_CODE_CEIL     8'h24
`define PMC_CODE_MHIGH    8'h25
`define PMC_CODE_MLOW     8'h26
`define PMC_CODE_RATE     8'h27
`define PMC_CODE_DROOP    8'h28
`define PMC_CODE_GAIN     8'h29
`define PMC_CODE_SCALE    8'h2A
`define PMC_CODE_DUTY     8'h32
`define PMC_CODE_FSW      8'h33
`define PMC_CODE_VINON    8'h35
`define PMC_CODE_VINOFF   8'h36
`define PMC_CODE_ILV      8'h37
`define PMC_CODE_IOFS     8'h39
`define PMC_CODE_OVF      8'h40
`define PMC_IX_CEIL       0
`define PMC_IX_MHIGH      1
`define PMC_IX_MLOW       2
`define PMC_IX_RATE       3
`define PMC_IX_DROOP      4
`define PMC_IX_GAIN       5
`define PMC_IX_SCALE      6
`define PMC_IX_DUTY       7
`define PMC_IX_FSW        8
`define PMC_IX_VINON      9
`define PMC_IX_VINOFF     10
`define PMC_IX_ILV        11
`define PMC_IX_IOFS       12
`define PMC_IX_OVF        13
`define PMC_RST_CEIL      16'hFFFF
`define PMC_RST_OTHER     16'h0000
`define PMC_RST_OVF       16'hFFFF
`define PMC_ILV_MASK      16'h0FFF
`define PMC_ILV_GID       11:8
`define PMC_ILV_CNT       7:4
`define PMC_ILV_POS       3:0
`define PMC_MSEL_HIGH     2'h1
`define PMC_MSEL_LOW      2'h2
`define PMC_CEIL_PCT      24'h00006E
`define PMC_PCT_BASE      24'h000064
`define PMC_MODE_LINEAR   3'h0
`define PMC_MODE_VID      3'h1
`define PMC_MODE_DIRECT   3'h2
`define PMC_MANT_MSB      10
`define PMC_DROOP_SHIFT   10
`define PMC_CLK_NS        8
`define PMC_RAMP_TICK_NS  1000
`define PMC_RAMP_TICK_CYC (`PMC_RAMP_TICK_NS / `PMC_CLK_NS)
`define PMC_TICK_W        7
`endif

/* File: hdl/pmc_pkg.sv */
// types shared by the power-converter command bank
package pmc_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  code;
      logic [15:0] data;
   } pmc_req_t;
   typedef struct packed {
      logic        valid;
      logic        ack;
      logic [15:0] data;
   } pmc_rsp_t;
   typedef enum logic [2:0] {
      PMC_RS_IDLE = 3'b001,
      PMC_RS_UP   = 3'b010,
      PMC_RS_DOWN = 3'b100
   } pmc_ramp_t;
endpackage : pmc_pkg
